// [port_io_pkg.sv]
// constants, register map and carrier types for the two-port i/o block
package port_io_pkg;

    localparam int WB_ADR_W = 10;
    localparam int PORT_W = 8;

    // register indices; byte address is four times the index
    localparam logic [7:0] PORT_DRIVER_CONFIG_IDX = 8'h00;
    localparam logic [7:0] PORT1_DATA_IDX = 8'h01;
    localparam logic [7:0] PORT2_DATA_IDX = 8'h02;
    localparam logic [7:0] PORT2_DIRECTION_IDX = 8'hf6;
    localparam logic [7:0] PORT0_PORT1_MODE_IDX = 8'hf8;
    localparam logic [7:0] WAKE_EDGE_CONTROL_IDX = 8'h10;

    // field positions
    localparam int CFG_PORT1_OPEN_DRAIN_BIT = 1;
    localparam int CFG_PORT2_OPEN_DRAIN_BIT = 2;
    localparam int MODE_PORT1_INPUT_BIT = 3;
    localparam int CTRL_EDGE_FROM_PORT2_BIT = 0;
    localparam int CTRL_WAKE_USE_AND_BIT = 1;
    localparam int CTRL_WAKE_ENABLE_BIT = 2;

    // reset values
    localparam logic [7:0] DRV_CFG_RESET = 8'h00;
    localparam logic [7:0] P2DIR_RESET = 8'hff;
    localparam logic [7:0] MODE01_RESET = 8'hcf;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;

    typedef struct packed {
        logic [PORT_W-1:0] out;
        logic [PORT_W-1:0] oe;
    } pin_drive_s;

endpackage

// [pin_sync.sv]
// three-stage synchroniser; output moves once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] level_reg;
    logic [W-1:0] level_next;

    always_comb begin
        level_next = level_reg;
        for (int i = 0; i < W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                level_next[i] = s3_reg[i];
            end
        end
    end

    // s1 feeds s2 only, so metastability cannot leak into logic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            level_reg <= '0;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level_o = level_reg;
endmodule

// [pin_driver.sv]
// per-bit pin driver: push-pull or open-drain, registered to the pins
`timescale 1ns/1ps
module pin_driver #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] latch_i,
    input wire logic [W-1:0] is_input_i,
    input wire logic open_drain_i,
    output port_io_pkg::pin_drive_s drive_o
);
    port_io_pkg::pin_drive_s drive_reg;
    port_io_pkg::pin_drive_s drive_next;

    for (genvar b = 0; b < W; b++) begin : g_bit
        // open-drain never drives high: it releases the pin instead
        always_comb begin
            if (is_input_i[b]) begin
                drive_next.out[b] = 1'b0;
                drive_next.oe[b] = 1'b0;
            end else if (open_drain_i) begin
                drive_next.out[b] = 1'b0;
                drive_next.oe[b] = ~latch_i[b];
            end else begin
                drive_next.out[b] = latch_i[b];
                drive_next.oe[b] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drive_reg <= '0;
        end else begin
            drive_reg <= drive_next;
        end
    end

    assign drive_o = drive_reg;

    AST_INPUT_NOT_DRIVEN: assert property (@(posedge clk_i) disable iff (rst_i)
        (drive_o.oe & $past(is_input_i)) == '0)
        else $error("driver enabled on a line set as input");
endmodule

// [port_io_control.sv]
// two 8-bit general ports: direction, driver type, wake gate, timer routing
//
// Overview of operation
// - after power-on reset every port1 line is input with drivers off
// - one bit of port_driver_config picks push-pull or open-drain for port1
// - stop-mode recovery returns port1 direction to its power-on default
// - each port2 line is set input or output by its own direction bit
// - all port2 output lines share one push-pull or open-drain choice
// - power-on reset sets all eight port2 lines to input
// - an OR and an AND of the eight port2 inputs serve as wake sources
// - port2 bit 0 can feed the timer edge detector in demodulation mode
// - port2 works as plain i/o at all times, no alternate select needed
// - timer edge input comes from third port bit 1 or port2 bit 0
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
module port_io_control (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic stop_recovery_i,
    input wire logic demod_mode_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [port_io_pkg::WB_ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [7:0] port1_pin_i,
    input wire logic [7:0] port2_pin_i,
    input wire logic third_port_bit1_i,
    output port_io_pkg::pin_drive_s port1_drive_o,
    output port_io_pkg::pin_drive_s port2_drive_o,
    output logic wake_or_o,
    output logic wake_and_o,
    output logic wake_o,
    output logic timer_edge_o
);
    logic [7:0] port1_in;
    logic [7:0] port2_in;
    logic p3_1_in;
    logic [16:0] sync_level;

    pin_sync #(.W(17)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i({third_port_bit1_i, port2_pin_i, port1_pin_i}),
        .level_o(sync_level)
    );

    assign port1_in = sync_level[7:0];
    assign port2_in = sync_level[15:8];
    assign p3_1_in = sync_level[16];

    // ---------------- bus slave ----------------
    logic ack_reg;
    logic ack_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    logic [7:0] reg_index;
    logic access;
    logic wr_en;

    logic [7:0] drv_cfg_reg;
    logic [7:0] drv_cfg_next;
    logic [7:0] port1_latch_reg;
    logic [7:0] port1_latch_next;
    logic [7:0] port2_latch_reg;
    logic [7:0] port2_latch_next;
    logic [7:0] p2dir_reg;
    logic [7:0] p2dir_next;
    logic [7:0] mode01_reg;
    logic [7:0] mode01_next;
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;

    logic [7:0] port1_is_input;
    logic port1_open_drain;
    logic port2_open_drain;
    logic [7:0] port1_read;
    logic [7:0] port2_read;

    assign reg_index = adr_i[port_io_pkg::WB_ADR_W-1:2];
    assign access = cyc_i && stb_i;
    // a write lands on the edge where the master sees ack high
    assign wr_en = access && we_i && ack_reg && sel_i[0];

    assign port1_is_input =
        {8{mode01_reg[port_io_pkg::MODE_PORT1_INPUT_BIT]}};
    assign port1_open_drain =
        drv_cfg_reg[port_io_pkg::CFG_PORT1_OPEN_DRAIN_BIT];
    assign port2_open_drain =
        drv_cfg_reg[port_io_pkg::CFG_PORT2_OPEN_DRAIN_BIT];

    // inputs show the pin, outputs show the latch
    assign port1_read = (port1_is_input & port1_in)
        | (~port1_is_input & port1_latch_reg);
    assign port2_read = (p2dir_reg & port2_in)
        | (~p2dir_reg & port2_latch_reg);

    always_comb begin
        ack_next = access && !ack_reg;
        dat_next = dat_reg;
        if (access && !ack_reg) begin
            dat_next = 32'h0000_0000;
            if (!we_i) begin
                case (reg_index)
                    port_io_pkg::PORT_DRIVER_CONFIG_IDX: begin
                        dat_next[7:0] = drv_cfg_reg;
                    end
                    port_io_pkg::PORT1_DATA_IDX: begin
                        dat_next[7:0] = port1_read;
                    end
                    port_io_pkg::PORT2_DATA_IDX: begin
                        dat_next[7:0] = port2_read;
                    end
                    port_io_pkg::PORT2_DIRECTION_IDX: begin
                        dat_next[7:0] = p2dir_reg;
                    end
                    port_io_pkg::PORT0_PORT1_MODE_IDX: begin
                        dat_next[7:0] = mode01_reg;
                    end
                    port_io_pkg::WAKE_EDGE_CONTROL_IDX: begin
                        dat_next[7:0] = ctrl_reg;
                    end
                    default: begin
                        dat_next = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

    // ---------------- configuration and data registers ----------------
    always_comb begin
        drv_cfg_next = drv_cfg_reg;
        port1_latch_next = port1_latch_reg;
        port2_latch_next = port2_latch_reg;
        p2dir_next = p2dir_reg;
        mode01_next = mode01_reg;
        ctrl_next = ctrl_reg;
        if (wr_en) begin
            case (reg_index)
                port_io_pkg::PORT_DRIVER_CONFIG_IDX: begin
                    drv_cfg_next = dat_i[7:0];
                end
                port_io_pkg::PORT1_DATA_IDX: begin
                    port1_latch_next = dat_i[7:0];
                end
                port_io_pkg::PORT2_DATA_IDX: begin
                    port2_latch_next = dat_i[7:0];
                end
                port_io_pkg::PORT2_DIRECTION_IDX: begin
                    p2dir_next = dat_i[7:0];
                end
                port_io_pkg::PORT0_PORT1_MODE_IDX: begin
                    mode01_next = dat_i[7:0];
                end
                port_io_pkg::WAKE_EDGE_CONTROL_IDX: begin
                    ctrl_next = dat_i[7:0];
                end
                default: begin
                    ctrl_next = ctrl_reg;
                end
            endcase
        end
        // recovery beats a same-cycle write so the port comes back safe
        if (stop_recovery_i) begin
            mode01_next[port_io_pkg::MODE_PORT1_INPUT_BIT] = 1'b1;
        end
    end

    // port2 direction is kept across stop-mode recovery
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drv_cfg_reg <= port_io_pkg::DRV_CFG_RESET;
            port1_latch_reg <= port_io_pkg::LATCH_RESET;
            port2_latch_reg <= port_io_pkg::LATCH_RESET;
            p2dir_reg <= port_io_pkg::P2DIR_RESET;
            mode01_reg <= port_io_pkg::MODE01_RESET;
            ctrl_reg <= port_io_pkg::CTRL_RESET;
        end else begin
            drv_cfg_reg <= drv_cfg_next;
            port1_latch_reg <= port1_latch_next;
            port2_latch_reg <= port2_latch_next;
            p2dir_reg <= p2dir_next;
            mode01_reg <= mode01_next;
            ctrl_reg <= ctrl_next;
        end
    end

    // ---------------- pin drivers ----------------
    pin_driver #(.W(8)) u_port1_drv (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .latch_i(port1_latch_reg),
        .is_input_i(port1_is_input),
        .open_drain_i(port1_open_drain),
        .drive_o(port1_drive_o)
    );

    // port2 has no alternate-function gate between latch and pin
    pin_driver #(.W(8)) u_port2_drv (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .latch_i(port2_latch_reg),
        .is_input_i(p2dir_reg),
        .open_drain_i(port2_open_drain),
        .drive_o(port2_drive_o)
    );

    // ---------------- wake gate and timer routing ----------------
    logic wake_or_reg;
    logic wake_or_next;
    logic wake_and_reg;
    logic wake_and_next;
    logic wake_reg;
    logic wake_next;
    logic edge_reg;
    logic edge_next;
    logic edge_from_port2;

    // the gate sees the pins whatever their direction, as a pin-level OR/AND
    assign edge_from_port2 = ctrl_reg[port_io_pkg::CTRL_EDGE_FROM_PORT2_BIT]
        && demod_mode_i;

    always_comb begin
        wake_or_next = |port2_in;
        wake_and_next = &port2_in;
        wake_next = 1'b0;
        if (ctrl_reg[port_io_pkg::CTRL_WAKE_ENABLE_BIT]) begin
            wake_next = ctrl_reg[port_io_pkg::CTRL_WAKE_USE_AND_BIT]
                ? wake_and_next : wake_or_next;
        end
        edge_next = edge_from_port2 ? port2_in[0] : p3_1_in;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_or_reg <= 1'b0;
            wake_and_reg <= 1'b0;
            wake_reg <= 1'b0;
            edge_reg <= 1'b0;
        end else begin
            wake_or_reg <= wake_or_next;
            wake_and_reg <= wake_and_next;
            wake_reg <= wake_next;
            edge_reg <= edge_next;
        end
    end

    assign wake_or_o = wake_or_reg;
    assign wake_and_o = wake_and_reg;
    assign wake_o = wake_reg;
    assign timer_edge_o = edge_reg;

    // ---------------- assertions ----------------
    AST_PORT1_INPUT_AFTER_RESET: assert property (@(posedge clk_i)
        disable iff (rst_i) $past(rst_i) |-> port1_drive_o.oe == 8'h00)
        else $error("port1 drives right after reset");

    AST_PORT1_OPEN_DRAIN_LOW_ONLY: assert property (@(posedge clk_i)
        disable iff (rst_i)
        $past(port1_open_drain) && !$past(rst_i)
        |-> port1_drive_o.out == 8'h00)
        else $error("port1 open-drain drives high");

    AST_PORT1_STOP_RECOVERY: assert property (@(posedge clk_i)
        disable iff (rst_i) stop_recovery_i |-> ##2 port1_drive_o.oe == 8'h00)
        else $error("port1 still driving after stop recovery");

    AST_PORT2_DIR_WRITE: assert property (@(posedge clk_i)
        disable iff (rst_i)
        wr_en && reg_index == port_io_pkg::PORT2_DIRECTION_IDX
        |=> ##1 port2_drive_o.oe == ($past(~dat_i[7:0], 2)
            & ~({8{$past(port2_open_drain)}} & $past(port2_latch_reg))))
        else $error("port2 direction write not reflected on pins");

    AST_PORT2_SHARED_DRIVER: assert property (@(posedge clk_i)
        disable iff (rst_i)
        $past(port2_open_drain) && !$past(rst_i)
        |-> port2_drive_o.out == 8'h00)
        else $error("port2 open-drain drives high");

    AST_PORT2_INPUT_AFTER_RESET: assert property (@(posedge clk_i)
        disable iff (rst_i) $past(rst_i) |=> port2_drive_o.oe == 8'h00)
        else $error("port2 drives right after reset");

    AST_WAKE_GATE: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (wake_and_o |-> wake_or_o) and (port2_in == 8'hff |=> wake_and_o)
        and (port2_in == 8'h00 |=> !wake_or_o))
        else $error("wake gate does not follow port2 inputs");

    AST_TIMER_EDGE_SOURCE: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !$past(rst_i) |-> timer_edge_o
            == ($past(edge_from_port2) ? $past(port2_in[0])
                : $past(p3_1_in)))
        else $error("timer edge input from wrong source");

    AST_READ_DATA: assert property (@(posedge clk_i)
        disable iff (rst_i)
        access && !we_i && !ack_reg
        && reg_index == port_io_pkg::PORT2_DATA_IDX
        |=> ack_o && dat_o[7:0] == $past(port2_read) && dat_o[31:8] == 24'h0)
        else $error("port2 read data wrong");

    AST_ACK_ONE_CYCLE: assert property (@(posedge clk_i)
        disable iff (rst_i) ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
endmodule

// [board_pins.sv]
// board model for one 8-bit port: device drive, external sources, pull-ups
`timescale 1ns/1ps
module board_pins (
    input wire port_io_pkg::pin_drive_s drive_i,
    input wire logic [7:0] ext_en_i,
    input wire logic [7:0] ext_val_i,
    output logic [7:0] pin_o
);
    // a line nobody drives floats high on the pull-up, as with open-drain
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (drive_i.oe[i]) begin
                pin_o[i] = drive_i.out[i];
            end else if (ext_en_i[i]) begin
                pin_o[i] = ext_val_i[i];
            end else begin
                pin_o[i] = 1'b1;
            end
        end
    end
endmodule

// [tb_port_io_control.sv]
// self-checking bench for the two-port i/o block
`timescale 1ns/1ps
module tb_port_io_control;
    logic clk_i, rst_i, stop_recovery_i, demod_mode_i;
    logic cyc_i, stb_i, we_i, ack_o, third_port_bit1_i;
    logic [9:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, rdata;
    logic [7:0] port1_pin_i, port2_pin_i;
    logic [7:0] ext1_en, ext1_val, ext2_en, ext2_val;
    port_io_pkg::pin_drive_s port1_drive_o, port2_drive_o;
    logic wake_or_o, wake_and_o, wake_o, timer_edge_o;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;

    port_io_control u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .stop_recovery_i(stop_recovery_i), .demod_mode_i(demod_mode_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .port1_pin_i(port1_pin_i), .port2_pin_i(port2_pin_i),
        .third_port_bit1_i(third_port_bit1_i),
        .port1_drive_o(port1_drive_o), .port2_drive_o(port2_drive_o),
        .wake_or_o(wake_or_o), .wake_and_o(wake_and_o), .wake_o(wake_o),
        .timer_edge_o(timer_edge_o));
    board_pins u_pins1 (.drive_i(port1_drive_o), .ext_en_i(ext1_en),
        .ext_val_i(ext1_val), .pin_o(port1_pin_i));
    board_pins u_pins2 (.drive_i(port2_drive_o), .ext_en_i(ext2_en),
        .ext_val_i(ext2_val), .pin_o(port2_pin_i));

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one classic cycle; ack and read data are the values sampled at the edge
    task automatic wb(input logic wr, input logic [7:0] idx,
                      input logic [7:0] data, input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= wr;
        adr_i <= {idx, 2'b00};
        sel_i <= sel;
        dat_i <= {24'h0, data};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rdata = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        chk({31'h0, ack_o}, 32'h1, "bus ack");
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] data);
        wb(1'b1, idx, data, 4'hf);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00, 4'hf);
        chk(rdata, {24'h0, exp}, "register read");
    endtask

    task automatic wait_cyc(input int k);
        repeat (k) @(posedge clk_i);
    endtask

    task automatic t_reset;
        chk(port1_drive_o.oe, 8'h00, "port1 oe after reset");
        chk(port2_drive_o.oe, 8'h00, "port2 oe after reset");
        rdchk(port_io_pkg::PORT_DRIVER_CONFIG_IDX, 8'h00);
        rdchk(port_io_pkg::PORT2_DIRECTION_IDX, 8'hff);
        rdchk(port_io_pkg::PORT0_PORT1_MODE_IDX, 8'hcf);
        rdchk(port_io_pkg::WAKE_EDGE_CONTROL_IDX, 8'h00);
        rdchk(8'h55, 8'h00);
        // a write without the low byte select must leave the register alone
        wb(1'b1, port_io_pkg::PORT_DRIVER_CONFIG_IDX, 8'hff, 4'he);
        rdchk(port_io_pkg::PORT_DRIVER_CONFIG_IDX, 8'h00);
    endtask

    task automatic t_port2;
        wr(port_io_pkg::PORT2_DATA_IDX, 8'ha5);
        wr(port_io_pkg::PORT2_DIRECTION_IDX, 8'h0f);
        wait_cyc(8);
        chk(port2_drive_o.oe, 8'hf0, "port2 oe per bit");
        chk(port2_drive_o.out & 8'hf0, 8'ha0, "port2 out");
        rdchk(port_io_pkg::PORT2_DATA_IDX, 8'hac);
        wr(port_io_pkg::PORT_DRIVER_CONFIG_IDX, 8'h04);
        wait_cyc(2);
        chk(port2_drive_o.oe, 8'h50, "port2 open-drain oe");
        chk(port2_drive_o.out, 8'h00, "port2 open-drain out");
    endtask

    task automatic t_port1;
        wr(port_io_pkg::PORT_DRIVER_CONFIG_IDX, 8'h00);
        wr(port_io_pkg::PORT1_DATA_IDX, 8'h3c);
        wr(port_io_pkg::PORT0_PORT1_MODE_IDX, 8'hc7);
        wait_cyc(2);
        chk(port1_drive_o.oe, 8'hff, "port1 push-pull oe");
        chk(port1_drive_o.out, 8'h3c, "port1 push-pull out");
        rdchk(port_io_pkg::PORT1_DATA_IDX, 8'h3c);
        wr(port_io_pkg::PORT_DRIVER_CONFIG_IDX, 8'h02);
        wait_cyc(2);
        chk(port1_drive_o.oe, 8'hc3, "port1 open-drain oe");
        chk(port1_drive_o.out, 8'h00, "port1 open-drain out");
    endtask

    task automatic t_stop;
        @(posedge clk_i);
        ext1_val <= 8'h96;
        stop_recovery_i <= 1'b1;
        @(posedge clk_i);
        stop_recovery_i <= 1'b0;
        wait_cyc(8);
        chk(port1_drive_o.oe, 8'h00, "port1 oe after recovery");
        rdchk(port_io_pkg::PORT0_PORT1_MODE_IDX, 8'hcf);
        rdchk(port_io_pkg::PORT2_DIRECTION_IDX, 8'h0f);
        rdchk(port_io_pkg::PORT1_DATA_IDX, 8'h96);
    endtask

    task automatic t_wake;
        logic [7:0] vals [3];
        vals = '{8'hff, 8'hef, 8'h00};
        wr(port_io_pkg::PORT2_DIRECTION_IDX, 8'hff);
        for (int m = 0; m < 2; m++) begin
            wr(port_io_pkg::WAKE_EDGE_CONTROL_IDX, {6'h01, m[0], 1'b0});
            for (int i = 0; i < 3; i++) begin
                @(posedge clk_i);
                ext2_val <= vals[i];
                wait_cyc(8);
                chk({31'h0, wake_or_o}, {31'h0, |vals[i]}, "or gate");
                chk({31'h0, wake_and_o}, {31'h0, &vals[i]}, "and gate");
                chk({31'h0, wake_o},
                    {31'h0, m[0] ? &vals[i] : |vals[i]}, "wake");
            end
        end
    endtask

    task automatic t_timer;
        wr(port_io_pkg::WAKE_EDGE_CONTROL_IDX, 8'h01);
        @(posedge clk_i);
        demod_mode_i <= 1'b1;
        ext2_val <= 8'h01;
        third_port_bit1_i <= 1'b0;
        wait_cyc(8);
        chk({31'h0, timer_edge_o}, 32'h1, "edge from port2");
        chk({31'h0, wake_o}, 32'h0, "wake disabled");
        @(posedge clk_i);
        ext2_val <= 8'h00;
        third_port_bit1_i <= 1'b1;
        wait_cyc(8);
        chk({31'h0, timer_edge_o}, 32'h0, "edge from port2 low");
        @(posedge clk_i);
        demod_mode_i <= 1'b0;
        wait_cyc(3);
        chk({31'h0, timer_edge_o}, 32'h1, "edge from third port");
        wr(port_io_pkg::WAKE_EDGE_CONTROL_IDX, 8'h00);
        @(posedge clk_i);
        demod_mode_i <= 1'b1;
        ext2_val <= 8'h01;
        third_port_bit1_i <= 1'b0;
        wait_cyc(8);
        chk({31'h0, timer_edge_o}, 32'h0, "edge select off");
    endtask

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ceiling well above the fewer than two hundred cycles the scenarios need
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            $display("[ERR] %0t run did not finish", $time);
            summarize();
        end
    end

    initial begin
        rst_i = 1'b1;
        stop_recovery_i = 1'b0;
        demod_mode_i = 1'b0;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 10'h000;
        sel_i = 4'h0;
        dat_i = 32'h0;
        third_port_bit1_i = 1'b0;
        ext1_en = 8'hff;
        ext1_val = 8'h00;
        ext2_en = 8'hff;
        ext2_val = 8'h3c;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_port2();
        t_port1();
        t_stop();
        t_wake();
        t_timer();
        summarize();
    end
endmodule
